/* File: verilog/i2c_target.sv */
/*
 * Two-wire bus target: address match, register pointer, write and
 * read of an external register file through a simple port.
 * Assumes the register file answers reads combinationally and that
 * bus lines arrive synchronous to the 40 MHz core clock.
 */
`timescale 1ns/10ps
`include "i2c_target_map.svh"
module i2c_target (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Bus lines (data is open drain)
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    // Address select strap (register 0x7c bit 7)
    input  wire logic       i_addr_sel,
    // Register file port
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    output logic            o_reg_we,
    output logic            o_reg_re,
    input  wire logic [7:0] i_reg_rdata
);
    // ------------------------------------------------------------------
    // Line watcher
    // ------------------------------------------------------------------
    i2c_line_if line ();

    i2c_line_watch u_watch (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_scl      (i_scl),
        .i_sda      (i_sda),
        .line       (line)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        i2c_target_pkg::state_type st;     // Protocol state
        i2c_target_pkg::state_type after;  // State after acknowledge slot
        logic [7:0] shift;                 // Byte shifter
        logic [3:0] cnt;                   // Bits done in byte
        logic       ack_drive;             // Drive low in ninth clock
        logic       rd_dir;                // Direction bit of last address
        logic       rd_nack;               // Controller declined more data
        logic       sda_oe;                // Data line driven low
        logic [7:0] ptr;                   // Register pointer
        logic [7:0] wdata;                 // Write data out
        logic       we;                    // Write strobe
        logic       re;                    // Read fetch strobe
        logic       addr_sel;              // Strap sampled every core clock
    } tgt_type;

    tgt_type cur_ff;
    tgt_type nxt_cur;
    logic [6:0] own_addr;                  // Selected target address

    always_comb begin
        own_addr = cur_ff.addr_sel ? `TGT_ADDR_ALTERNATE : `TGT_ADDR_DEFAULT;
    end

    // ------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cur          = cur_ff;
        nxt_cur.we       = 1'b0;
        nxt_cur.re       = 1'b0;
        nxt_cur.addr_sel = i_addr_sel;
        // start always restarts, also repeated start
        if (line.ev.start) begin
            nxt_cur.st     = i2c_target_pkg::ST_ADDR;
            nxt_cur.cnt    = 4'h0;
            nxt_cur.sda_oe = 1'b0;
        // stop mid byte drops the byte
        end else if (line.ev.stop) begin
            nxt_cur.st     = i2c_target_pkg::ST_IDLE;
            nxt_cur.sda_oe = 1'b0;
        end else begin
            unique case (cur_ff.st)
                i2c_target_pkg::ST_IDLE: begin
                    nxt_cur.sda_oe = 1'b0;
                end
                i2c_target_pkg::ST_ADDR,
                i2c_target_pkg::ST_PTR,
                i2c_target_pkg::ST_WDATA: begin
                    if (line.ev.scl_rise) begin
                        nxt_cur.shift = {cur_ff.shift[6:0], line.ev.sda};
                        nxt_cur.cnt   = cur_ff.cnt + 4'h1;
                    end
                    // eighth bit done, decide acknowledge on fall
                    if (line.ev.scl_fall && cur_ff.cnt == `BYTE_BITS) begin
                        nxt_cur.cnt       = 4'h0;
                        nxt_cur.st        = i2c_target_pkg::ST_ACK;
                        nxt_cur.ack_drive = 1'b1;
                        nxt_cur.sda_oe    = 1'b1;
                        if (cur_ff.st == i2c_target_pkg::ST_ADDR) begin
                            nxt_cur.rd_dir = cur_ff.shift[0];
                            if (cur_ff.shift[7:1] != own_addr) begin
                                nxt_cur.st     = i2c_target_pkg::ST_IDLE;
                                nxt_cur.sda_oe = 1'b0;
                            end else if (cur_ff.shift[0] == `DIR_READ) begin
                                nxt_cur.after = i2c_target_pkg::ST_RDATA;
                                nxt_cur.re    = 1'b1;
                            end else begin
                                nxt_cur.after = i2c_target_pkg::ST_PTR;
                            end
                        end else if (cur_ff.st == i2c_target_pkg::ST_PTR) begin
                            nxt_cur.ptr   = cur_ff.shift;
                            nxt_cur.after = i2c_target_pkg::ST_WDATA;
                        end else begin
                            nxt_cur.wdata = cur_ff.shift;
                            nxt_cur.we    = 1'b1;
                            nxt_cur.after = i2c_target_pkg::ST_WDATA;
                        end
                    end
                end
                i2c_target_pkg::ST_ACK: begin
                    if (line.ev.scl_fall) begin
                        nxt_cur.ack_drive = 1'b0;
                        nxt_cur.st        = cur_ff.after;
                        nxt_cur.sda_oe    = 1'b0;
                        if (cur_ff.after == i2c_target_pkg::ST_RDATA) begin
                            // drive MSB of read byte first
                            nxt_cur.shift  = i_reg_rdata;
                            nxt_cur.sda_oe = ~i_reg_rdata[7];
                            nxt_cur.cnt    = 4'h0;
                        end
                    end
                end
                i2c_target_pkg::ST_RDATA: begin
                    if (line.ev.scl_fall) begin
                        nxt_cur.cnt = cur_ff.cnt + 4'h1;
                        if (cur_ff.cnt == `BYTE_BITS - 4'h1) begin
                            nxt_cur.sda_oe = 1'b0;
                            nxt_cur.ptr    = cur_ff.ptr + 8'h01;
                        end else if (cur_ff.cnt == `BYTE_BITS) begin
                            if (cur_ff.rd_nack) begin
                                nxt_cur.st = i2c_target_pkg::ST_IDLE;
                            end else begin
                                nxt_cur.shift  = i_reg_rdata;
                                nxt_cur.sda_oe = ~i_reg_rdata[7];
                                nxt_cur.cnt    = 4'h0;
                            end
                        end else begin
                            nxt_cur.shift  = {cur_ff.shift[6:0], 1'b0};
                            nxt_cur.sda_oe = ~cur_ff.shift[6];
                        end
                    end
                    if (line.ev.scl_rise && cur_ff.cnt == `BYTE_BITS) begin
                        nxt_cur.rd_nack = line.ev.sda;
                        nxt_cur.re      = ~line.ev.sda;
                    end
                end
                default: begin
                    nxt_cur.st = i2c_target_pkg::ST_IDLE;
                end
            endcase
        end
        // pointer steps after each written byte
        if (cur_ff.we) begin
            nxt_cur.ptr = cur_ff.ptr + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_ff <= '{st: i2c_target_pkg::ST_IDLE, after: i2c_target_pkg::ST_IDLE,
                        shift: 8'h00, cnt: 4'h0, ack_drive: 1'b0, rd_dir: 1'b0,
                        rd_nack: 1'b0, sda_oe: 1'b0, ptr: 8'h00, wdata: 8'h00,
                        we: 1'b0, re: 1'b0, addr_sel: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open drain: only ever drives low
    assign o_sda       = 1'b0;
    assign o_sda_oe    = cur_ff.sda_oe;
    assign o_reg_addr  = cur_ff.ptr;
    assign o_reg_wdata = cur_ff.wdata;
    assign o_reg_we    = cur_ff.we;
    assign o_reg_re    = cur_ff.re;
endmodule

/* File: shared/i2c_target_map.svh */
/*
 * Constants of the two-wire target interface: addresses, byte layout,
 * and timing counts derived from the 40 MHz core clock.
 * Assumes inclusion by bare name from design files.
 */
`ifndef I2C_TARGET_MAP_SVH
`define I2C_TARGET_MAP_SVH

// ----------------------------------------------------------------------
// Target addresses
// ----------------------------------------------------------------------
`define TGT_ADDR_DEFAULT   7'h4d
`define TGT_ADDR_ALTERNATE 7'h4e
`define ADDR_SELECT_REG    8'h7c
`define ADDR_SELECT_BIT    7

// ----------------------------------------------------------------------
// Byte layout
// ----------------------------------------------------------------------
`define BYTE_BITS          4'h8
`define DIR_WRITE          1'h0
`define DIR_READ           1'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CORE_CLK_KHZ       40000
`define FAST_SCL_KHZ       400
`define STD_SCL_KHZ        100
`define CYCLES_PER_FAST_SCL (`CORE_CLK_KHZ / `FAST_SCL_KHZ)

`endif

/* File: shared/i2c_target_pkg.sv */
/*
 * Types of the two-wire target interface.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2c_target_pkg;

    // Protocol states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ADDR  = 6'h02,
        ST_PTR   = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_ACK   = 6'h20
    } state_type;

    // Bus line events seen on the sampled lines
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } line_event_type;

endpackage

/* File: shared/i2c_line_if.sv */
/*
 * Carries bus line events from the line watcher to the protocol engine.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
interface i2c_line_if;
    i2c_target_pkg::line_event_type ev;    // Line events, one cycle each, plus the current data level

    modport watcher (output ev);
    modport engine  (input  ev);
endinterface

/* File: verilog/i2c_line_watch.sv */
/*
 * Watches the clock and data lines and reports start, stop and clock
 * edges as one-cycle events.
 * Assumes the lines are already synchronous to the core clock.
 */
`timescale 1ns/10ps
module i2c_line_watch (
    // Clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_rst,
    // Bus lines
    input  wire logic  i_scl,
    input  wire logic  i_sda,
    // Events out
    i2c_line_if.watcher line
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic scl;    // Previous clock line
        logic sda;    // Previous data line
    } watch_type;

    watch_type cur_ff;
    watch_type nxt_cur;

    // Remember previous line levels
    always_comb begin
        nxt_cur.scl = i_scl;
        nxt_cur.sda = i_sda;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_ff <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // data edges only meaningful while clock high
    always_comb begin
        line.ev.start    = cur_ff.scl & i_scl & cur_ff.sda & ~i_sda;
        line.ev.stop     = cur_ff.scl & i_scl & ~cur_ff.sda & i_sda;
        line.ev.scl_rise = ~cur_ff.scl & i_scl;
        line.ev.scl_fall = cur_ff.scl & ~i_scl;
        line.ev.sda      = i_sda;
    end
endmodule

/* File: tb/i2c_target_chk.sv */
/*
 * Port checker of the bus target.
 * Assumes binding onto i2c_target, one core clock.
 */
`timescale 1ns/10ps
module i2c_target_chk (
    // Clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    // Bus and register port
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda,
    input wire logic       o_sda_oe,
    input wire logic [7:0] o_reg_addr,
    input wire logic       o_reg_we,
    input wire logic       o_reg_re
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sda_zero_a: assert property (o_sda_oe |-> o_sda == 1'h0)
        else $error("data drive not low");
    oe_edge_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
        else $error("data drive moved with clock high");
    oe_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*3])
        else $error("data drive too short");
    we_pulse_a: assert property (o_reg_we |=> !o_reg_we)
        else $error("write strobe longer than one cycle");
    re_pulse_a: assert property (o_reg_re |=> !o_reg_re)
        else $error("read fetch strobe longer than one cycle");
    ptr_step_a: assert property (o_reg_we |=> o_reg_addr == $past(o_reg_addr) + 8'h01)
        else $error("pointer did not advance");
    stop_quiet_a: assert property ((i_scl && $past(i_scl) && $rose(i_sda)) |->
        ##1 !o_reg_we [*4])
        else $error("write after stop");
    we_re_a: assert property (!(o_reg_we && o_reg_re))
        else $error("read and write together");
    rst_idle_a: assert property ($fell(i_rst) |-> !o_sda_oe && o_reg_addr == 8'h00)
        else $error("not idle after reset");

    cover property (o_reg_we);
    cover property (o_reg_re);
    cover property ($rose(o_sda_oe));
endmodule

bind i2c_target i2c_target_chk i2c_target_chk_i (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_reg_addr(o_reg_addr),
    .o_reg_we(o_reg_we), .o_reg_re(o_reg_re)
);

/* File: tb/i2c_host_model.sv */
/*
 * Bus controller model: clock made here, data open drain.
 * Assumes a pull-up on the data wire outside.
 */
`timescale 1ns/10ps
module i2c_host_model (
    // Clock
    input  wire logic i_core_clk,
    // Bus lines
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    int half = 52;                    // Core cycles per clock half

    // Clock stands high outside frames
    initial begin
        o_scl = 1'h1;
        o_sda_low = 1'h0;
    end

    // Wait n edges, then step off the edge
    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic bitx(input logic b, output logic r);
        o_sda_low = ~b;
        wt(half);
        o_scl = 1'h1;
        wt(half);
        r = i_sda;
        o_scl = 1'h0;
        wt(4);
    endtask

    task automatic start();
        wt(half);
        o_sda_low = 1'h1;
        wt(half);
        o_scl = 1'h0;
        wt(4);
    endtask

    task automatic rstart();
        o_sda_low = 1'h0;
        wt(half);
        o_scl = 1'h1;
        start();
    endtask

    task automatic stop();
        o_sda_low = 1'h1;
        wt(half);
        o_scl = 1'h1;
        wt(half);
        o_sda_low = 1'h0;
        wt(half);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'h1, r);
        ack = ~r;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'h1, d[i]);
        bitx(last, r);
    endtask
endmodule

/* File: tb/pmic_i2c_target_interface_tb_top.sv */
/*
 * Bench of the bus target: random traffic through the controller model.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/10ps
`include "i2c_target_map.svh"
module pmic_i2c_target_interface_tb_top;
    logic        i_core_clk, i_rst, i_addr_sel, scl, sda_low, o_sda, o_sda_oe;
    logic        o_reg_we, o_reg_re, a;
    logic [7:0]  o_reg_addr, o_reg_wdata, p, d;
    logic [7:0]  mem [256];           // Register file behind the port
    logic [7:0]  exp [256];           // Expected register contents
    logic [31:0] rs = 32'h59;         // Xorshift state
    int          bad_count, num_checks, n;
    wire         sda_w = ~(sda_low | (o_sda_oe & ~o_sda)); // Pulled-up wire
    wire [7:0]   rdata = mem[o_reg_addr];

    i2c_host_model host_i (.i_core_clk(i_core_clk), .i_sda(sda_w), .o_scl(scl),
        .o_sda_low(sda_low));
    i2c_target i2c_target_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(scl),
        .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel),
        .o_reg_addr(o_reg_addr), .o_reg_wdata(o_reg_wdata), .o_reg_we(o_reg_we),
        .o_reg_re(o_reg_re), .i_reg_rdata(rdata));

    // Register file write port
    always @(posedge i_core_clk) begin
        if (o_reg_we) mem[o_reg_addr] <= o_reg_wdata;
    end

    initial begin
        i_core_clk = 1'h0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction

    // Own address with direction bit
    function automatic logic [7:0] dev(input logic rd);
        return {i_addr_sel ? `TGT_ADDR_ALTERNATE : `TGT_ADDR_DEFAULT, rd};
    endfunction

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Start, address, pointer with acks checked
    task automatic head(input logic [7:0] ptr);
        host_i.start();
        host_i.wbyte(dev(1'h0), a);
        check("addr ack", 8'h01, {7'h00, a});
        host_i.wbyte(ptr, a);
        check("ptr ack", 8'h01, {7'h00, a});
    endtask

    task automatic wr(input logic [7:0] ptr, input int cnt);
        head(ptr);
        for (int k = 0; k < cnt; k++) begin
            d = rnd();
            exp[8'(ptr + k)] = d;
            host_i.wbyte(d, a);
            check("data ack", 8'h01, {7'h00, a});
        end
        host_i.stop();
    endtask

    task automatic rd(input logic [7:0] ptr, input int cnt);
        head(ptr);
        host_i.rstart();
        host_i.wbyte(dev(1'h1), a);
        check("read addr ack", 8'h01, {7'h00, a});
        for (int k = 0; k < cnt; k++) begin
            host_i.rbyte(k == cnt - 1, d);
            check("read data", exp[8'(ptr + k)], d);
        end
        host_i.stop();
    endtask

    // Main sequence
    initial begin
        i_rst = 1'h1;
        i_addr_sel = 1'h0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
            exp[i] = mem[i];
        end
        repeat (6) @(posedge i_core_clk);
        #1 i_rst = 1'h0;
        repeat (2) @(posedge i_core_clk);
        #1;
        // Write then read back, both addresses
        for (int t = 0; t < 4; t++) begin
            i_addr_sel = t[0];
            p = (t == 3) ? 8'hfd : rnd();
            n = (t == 3) ? 3 : 1 + rnd() % 2;
            wr(p, n);
            rd(p, n);
        end
        // Foreign addresses stay unanswered
        for (int t = 0; t < 2; t++) begin
            d = rnd();
            host_i.start();
            host_i.wbyte(t == 0 ? {`TGT_ADDR_DEFAULT, 1'h0} : {3'h0, d[4:0]}, a);
            check("foreign ack", 8'h00, {7'h00, a});
            host_i.wbyte(rnd(), a);
            check("ignored ack", 8'h00, {7'h00, a});
            host_i.stop();
        end
        // Stop inside a data byte
        head(8'h10);
        for (int b = 0; b < 4; b++) begin
            d = rnd();
            host_i.bitx(d[0], a);
        end
        host_i.stop();
        rd(8'h10, 1);
        // Standard mode clock
        // Bus period of 400 core cycles, exactly 100 kHz
        host_i.half = 198;
        wr(8'h40, 1);
        rd(8'h40, 1);
        complete_run();
    end

    // Hang guard
    initial begin
        repeat (95000) @(posedge i_core_clk);
        bad_count++;
        complete_run();
    end
endmodule
